/* File: rtl/jtag_isp_pkg.sv */
// Constants, field layout and state types for the test-port status and security block.
// Assumes a single 50 MHz system clock; all pin inputs are synchronised inside the block.
package jtag_isp_pkg;

  // Shift register and bus widths
  localparam int IR_W = 8;
  localparam int DR_W = 16;
  localparam int REG_W = 8;
  localparam int SECT_N = 12; // 8 primary plus 4 secondary sectors
  localparam int SECT_W = 4;
  localparam int BYTE_W = 8;

  // Port-enable register, offset from config_reg_base
  localparam logic [7:0] PORT_EN_OFFSET = 8'hC7;
  localparam int PORT_EN_BIT = 0;
  localparam logic [REG_W-1:0] PORT_EN_RESET = 8'h00;

  // Pin synchroniser layout
  localparam int SYNC_N = 3;
  localparam int SYNC_2ND = 1;
  localparam int SYNC_3RD = 2;
  localparam int PIN_N = 4;
  localparam int PIN_TCK = 0;
  localparam int PIN_TMS = 1;
  localparam int PIN_TDI = 2;
  localparam int PIN_RSTN = 3;
  localparam logic [PIN_N-1:0] LVL_RESET = 4'h0;

  // Instruction codes (plain defaults; the true encoding is not known here)
  localparam logic [IR_W-1:0] IR_CAPTURE = 8'h01;
  localparam logic [IR_W-1:0] IR_NONE = 8'h00;
  localparam logic [IR_W-1:0] CMD_ENTRY_PP = 8'h10; // config_mode_entry_cmd, push-pull
  localparam logic [IR_W-1:0] CMD_ENTRY_OD = 8'h11; // config_mode_entry_cmd, open-drain
  localparam logic [IR_W-1:0] CMD_EXIT = 8'h12; // config_mode_exit_cmd
  localparam logic [IR_W-1:0] CMD_CLEAR = 8'h13; // fail_flag_clear_cmd
  localparam logic [IR_W-1:0] CMD_PROG = 8'h14;
  localparam logic [IR_W-1:0] CMD_SECT_ERASE = 8'h15;
  localparam logic [IR_W-1:0] CMD_CHIP_ERASE = 8'h16;
  localparam logic [IR_W-1:0] CMD_READ = 8'h17;

  // Data register fields
  localparam int DR_ADDR_LSB = 0;
  localparam int DR_DATA_LSB = 8;
  localparam int DR_SECT_LSB = 0;

  // Flash operation kinds
  localparam logic [1:0] OP_NONE = 2'h0;
  localparam logic [1:0] OP_PROG = 2'h1;
  localparam logic [1:0] OP_SECT = 2'h2;
  localparam logic [1:0] OP_CHIP = 2'h3;

  // Test access port controller states
  typedef enum logic [15:0] {
    TAP_TLR = 16'h0001, TAP_RTI = 16'h0002, TAP_SEL_DR = 16'h0004, TAP_CAP_DR = 16'h0008,
    TAP_SHF_DR = 16'h0010, TAP_EX1_DR = 16'h0020, TAP_PAU_DR = 16'h0040,
    TAP_EX2_DR = 16'h0080, TAP_UPD_DR = 16'h0100, TAP_SEL_IR = 16'h0200,
    TAP_CAP_IR = 16'h0400, TAP_SHF_IR = 16'h0800, TAP_EX1_IR = 16'h1000,
    TAP_PAU_IR = 16'h2000, TAP_EX2_IR = 16'h4000, TAP_UPD_IR = 16'h8000
  } tap_t;

endpackage : jtag_isp_pkg

/* File: rtl/jtag_isp_status.sv */
// Test access port status, error, enable and security logic of the device.
// Assumes a flash engine on the same clock that takes op_start pulses and
// reports busy, done and fail; TCK, TMS, TDI and the reset pin are asynchronous.
// Overview of operation
// - Status and error pins are enabled only after the configuration entry command.
// - Error pin goes low when a sector erase or byte program fails.
// - Error stays low until clear command, or reset pulse after exit command.
// - Status pin is high while both flash arrays are readable.
// - Status pin is low during program, erase or secondary flash writes.
// - Entry command option makes status and error pins open-drain.
// - With security set, all reads are refused.
// - With security set, full-chip erase is the only flash operation accepted over the port.
// - Successful full-chip erase clears the security state.
// - Each sector has a protect bit; erasing a protected sector is rejected.
// - Port-enable register bit 0 enables the test pins, 0 disables them.
// - Pins dedicated by nonvolatile bit ignore the device reset.
// - Pins enabled only by register are blocked by an active device reset.
// - Delivered state: memory reads as ones, configuration registers as zero.
// - Test pins are active if nonvolatile bit, register bit or product term.
// - Port-enable register sits at offset C7h and clears on device reset.
// - Test data output stays an input until the entry command arrives.
`timescale 1ns/1ps
module jtag_isp_status (
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_RST,
  // Test port pins and device reset pin
  input wire logic I_TCK,
  input wire logic I_TMS,
  input wire logic I_TDI,
  input wire logic I_DEV_RESET_N,
  output logic O_TDO,
  output logic O_TDO_OE,
  // Status and error pins
  output logic O_PROG_BUSY_N_OUT,
  output logic O_PROG_BUSY_N_OE,
  output logic O_PROG_FAIL_N_OUT,
  output logic O_PROG_FAIL_N_OE,
  // Pin selection sources
  input wire logic I_NVM_DEDICATED,
  input wire logic I_TEST_PINS_SELECT_TERM,
  output logic O_TEST_PINS_ON,
  // Microcontroller register port
  input wire logic I_REG_WR,
  input wire logic [7:0] I_REG_ADDR,
  input wire logic [jtag_isp_pkg::REG_W-1:0] I_REG_WDATA,
  output logic [jtag_isp_pkg::REG_W-1:0] O_REG_RDATA,
  // Nonvolatile security and protection bits
  input wire logic I_SECURITY_BIT,
  input wire logic [jtag_isp_pkg::SECT_N-1:0] I_SECTOR_PROTECT,
  output logic O_READ_BLOCK,
  // Flash engine
  input wire logic I_FLASH_BUSY,
  input wire logic I_SEC_WRITING,
  input wire logic I_OP_DONE,
  input wire logic I_OP_FAIL,
  input wire logic [jtag_isp_pkg::BYTE_W-1:0] I_READ_DATA,
  output logic O_OP_START,
  output logic [1:0] O_OP_KIND,
  output logic [jtag_isp_pkg::SECT_W-1:0] O_OP_SECTOR,
  output logic [jtag_isp_pkg::BYTE_W-1:0] O_OP_ADDR,
  output logic [jtag_isp_pkg::BYTE_W-1:0] O_OP_DATA
);
  import jtag_isp_pkg::*;

  typedef struct packed {
    logic [PIN_N-1:0][SYNC_N-1:0] sync;
    logic [PIN_N-1:0] lvl;
    tap_t tap;
    logic [IR_W-1:0] ir;
    logic [IR_W-1:0] ir_shift;
    logic [DR_W-1:0] dr;
    logic cfg_mode;
    logic od_mode;
    logic exit_seen;
    logic fail;
    logic secure;
    logic strap_done;
    logic erase_pend;
    logic port_en;
    logic [REG_W-1:0] rdata;
    logic tdo;
    logic tdo_oe;
    logic busy_out;
    logic busy_oe;
    logic fail_out;
    logic fail_oe;
    logic pins_on;
    logic read_block;
    logic op_start;
    logic [1:0] op_kind;
    logic [SECT_W-1:0] op_sector;
    logic [BYTE_W-1:0] op_addr;
    logic [BYTE_W-1:0] op_data;
  } state_t;

  state_t s;
  state_t next_s;
  logic tck_rise;
  logic tck_fall;
  logic dev_rst;
  logic dev_rst_fall;
  logic jtag_on;
  logic tap_hold;
  logic ir_go;
  logic dr_go;
  logic clr_cmd;
  logic rst_clear;
  logic reject;
  logic busy_val;

  // Sector index is legal and not protected
  function automatic logic sect_ok(input logic [SECT_W-1:0] sect,
                                   input logic [SECT_N-1:0] prot);
    sect_ok = (32'(sect) < SECT_N) && !prot[sect];
  endfunction : sect_ok

  // Standard test access port state walk
  function automatic tap_t tap_next(input tap_t st, input logic tms);
    case (st)
      TAP_TLR: tap_next = tms ? TAP_TLR : TAP_RTI;
      TAP_RTI: tap_next = tms ? TAP_SEL_DR : TAP_RTI;
      TAP_SEL_DR: tap_next = tms ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: tap_next = tms ? TAP_EX1_DR : TAP_SHF_DR;
      TAP_SHF_DR: tap_next = tms ? TAP_EX1_DR : TAP_SHF_DR;
      TAP_EX1_DR: tap_next = tms ? TAP_UPD_DR : TAP_PAU_DR;
      TAP_PAU_DR: tap_next = tms ? TAP_EX2_DR : TAP_PAU_DR;
      TAP_EX2_DR: tap_next = tms ? TAP_UPD_DR : TAP_SHF_DR;
      TAP_UPD_DR: tap_next = tms ? TAP_SEL_DR : TAP_RTI;
      TAP_SEL_IR: tap_next = tms ? TAP_TLR : TAP_CAP_IR;
      TAP_CAP_IR: tap_next = tms ? TAP_EX1_IR : TAP_SHF_IR;
      TAP_SHF_IR: tap_next = tms ? TAP_EX1_IR : TAP_SHF_IR;
      TAP_EX1_IR: tap_next = tms ? TAP_UPD_IR : TAP_PAU_IR;
      TAP_PAU_IR: tap_next = tms ? TAP_EX2_IR : TAP_PAU_IR;
      TAP_EX2_IR: tap_next = tms ? TAP_UPD_IR : TAP_SHF_IR;
      TAP_UPD_IR: tap_next = tms ? TAP_SEL_DR : TAP_RTI;
      default: tap_next = TAP_TLR;
    endcase
  endfunction : tap_next

  // Whole next state in one place
  always_comb begin
    next_s = s;
    next_s.op_start = 1'b0;
    ir_go = 1'b0;
    dr_go = 1'b0;
    clr_cmd = 1'b0;
    reject = 1'b0;
    // Pins settle only once second and third stage agree, which filters glitches
    for (int k = 0; k < PIN_N; k++) begin
      next_s.sync[k] = {s.sync[k][SYNC_2ND:0], 1'b0};
      if (s.sync[k][SYNC_2ND] == s.sync[k][SYNC_3RD]) begin
        next_s.lvl[k] = s.sync[k][SYNC_3RD];
      end
    end
    next_s.sync[PIN_TCK][0] = I_TCK;
    next_s.sync[PIN_TMS][0] = I_TMS;
    next_s.sync[PIN_TDI][0] = I_TDI;
    next_s.sync[PIN_RSTN][0] = I_DEV_RESET_N;
    tck_rise = next_s.lvl[PIN_TCK] & ~s.lvl[PIN_TCK];
    tck_fall = ~next_s.lvl[PIN_TCK] & s.lvl[PIN_TCK];
    dev_rst = ~s.lvl[PIN_RSTN];
    dev_rst_fall = s.lvl[PIN_RSTN] & ~next_s.lvl[PIN_RSTN];
    jtag_on = I_NVM_DEDICATED | s.port_en | I_TEST_PINS_SELECT_TERM;
    // Dedicated pins ride through device reset, register-enabled ones do not
    tap_hold = ~jtag_on | (dev_rst & ~I_NVM_DEDICATED);

    // Port-enable register; upper bits are not stored
    if (I_REG_WR && I_REG_ADDR == PORT_EN_OFFSET) begin
      next_s.port_en = I_REG_WDATA[PORT_EN_BIT];
    end
    if (dev_rst) begin
      next_s.port_en = PORT_EN_RESET[PORT_EN_BIT];
    end
    next_s.rdata = PORT_EN_RESET;
    if (I_REG_ADDR == PORT_EN_OFFSET) begin
      next_s.rdata[PORT_EN_BIT] = s.port_en;
    end

    // Security bit caught once after reset release
    if (!s.strap_done) begin
      next_s.secure = I_SECURITY_BIT;
      next_s.strap_done = 1'b1;
    end

    // Controller walk on synchronised TCK edges
    if (tap_hold) begin
      next_s.tap = TAP_TLR;
      next_s.ir = IR_NONE;
    end else if (tck_rise) begin
      case (s.tap)
        TAP_CAP_DR: begin
          if (s.ir == CMD_READ) begin
            // Secured parts shift out zeros, never array content
            next_s.dr = s.secure ? '0 : {{(DR_W-BYTE_W){1'b0}}, I_READ_DATA};
          end
        end
        TAP_SHF_DR: next_s.dr = {s.lvl[PIN_TDI], s.dr[DR_W-1:1]};
        TAP_CAP_IR: next_s.ir_shift = IR_CAPTURE;
        TAP_SHF_IR: next_s.ir_shift = {s.lvl[PIN_TDI], s.ir_shift[IR_W-1:1]};
        TAP_UPD_IR: begin
          next_s.ir = s.ir_shift;
          ir_go = 1'b1;
        end
        TAP_UPD_DR: dr_go = 1'b1;
        default: ;
      endcase
      next_s.tap = tap_next(s.tap, s.lvl[PIN_TMS]);
    end
    if (tck_fall && s.tap == TAP_SHF_DR) begin
      next_s.tdo = s.dr[0];
    end else if (tck_fall && s.tap == TAP_SHF_IR) begin
      next_s.tdo = s.ir_shift[0];
    end

    // Instruction-level commands
    if (ir_go) begin
      case (s.ir_shift)
        CMD_ENTRY_PP, CMD_ENTRY_OD: begin
          next_s.cfg_mode = 1'b1;
          next_s.od_mode = (s.ir_shift == CMD_ENTRY_OD);
          next_s.exit_seen = 1'b0;
        end
        CMD_EXIT: begin
          next_s.cfg_mode = 1'b0;
          next_s.exit_seen = 1'b1;
        end
        CMD_CLEAR: clr_cmd = s.cfg_mode;
        CMD_CHIP_ERASE: begin
          // Chip erase is the one flash operation a secured part accepts
          if (s.cfg_mode && !s.erase_pend) begin
            next_s.op_start = 1'b1;
            next_s.op_kind = OP_CHIP;
            next_s.erase_pend = 1'b1;
          end
        end
        default: ;
      endcase
    end
    // Data-level commands, all blocked while secured
    if (dr_go && s.cfg_mode && !s.secure) begin
      if (s.ir == CMD_PROG) begin
        next_s.op_start = 1'b1;
        next_s.op_kind = OP_PROG;
        next_s.op_addr = s.dr[DR_ADDR_LSB +: BYTE_W];
        next_s.op_data = s.dr[DR_DATA_LSB +: BYTE_W];
      end else if (s.ir == CMD_SECT_ERASE) begin
        if (sect_ok(s.dr[DR_SECT_LSB +: SECT_W], I_SECTOR_PROTECT)) begin
          next_s.op_start = 1'b1;
          next_s.op_kind = OP_SECT;
          next_s.op_sector = s.dr[DR_SECT_LSB +: SECT_W];
        end else begin
          reject = 1'b1;
        end
      end
    end

    // A clean chip erase leaves the part blank and unsecured
    if (I_OP_DONE && s.erase_pend) begin
      next_s.erase_pend = 1'b0;
      if (!I_OP_FAIL) begin
        next_s.secure = 1'b0;
      end
    end

    // Sticky error flag; a new failure beats a clear in the same cycle
    rst_clear = dev_rst_fall & s.exit_seen;
    if (rst_clear) begin
      next_s.exit_seen = 1'b0;
    end
    if (clr_cmd || rst_clear) begin
      next_s.fail = 1'b0;
    end
    if (I_OP_FAIL || reject) begin
      next_s.fail = 1'b1;
    end

    // Pin drivers; open-drain only pulls low, so wired-OR across parts works
    busy_val = ~(I_FLASH_BUSY | I_SEC_WRITING | s.op_start);
    next_s.busy_out = s.od_mode ? 1'b0 : busy_val;
    next_s.busy_oe = s.cfg_mode & (~s.od_mode | ~busy_val);
    next_s.fail_out = s.od_mode ? 1'b0 : ~s.fail;
    next_s.fail_oe = s.cfg_mode & (~s.od_mode | s.fail);
    next_s.tdo_oe = s.cfg_mode & jtag_on;
    next_s.pins_on = jtag_on;
    next_s.read_block = s.secure;
  end

  // State register; delivered state is all configuration bits at zero
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      s <= '0;
      s.tap <= TAP_TLR;
      s.lvl <= LVL_RESET;
      s.busy_out <= 1'b1;
      s.fail_out <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from the state register
  assign O_TDO = s.tdo;
  assign O_TDO_OE = s.tdo_oe;
  assign O_PROG_BUSY_N_OUT = s.busy_out;
  assign O_PROG_BUSY_N_OE = s.busy_oe;
  assign O_PROG_FAIL_N_OUT = s.fail_out;
  assign O_PROG_FAIL_N_OE = s.fail_oe;
  assign O_TEST_PINS_ON = s.pins_on;
  assign O_REG_RDATA = s.rdata;
  assign O_READ_BLOCK = s.read_block;
  assign O_OP_START = s.op_start;
  assign O_OP_KIND = s.op_kind;
  assign O_OP_SECTOR = s.op_sector;
  assign O_OP_ADDR = s.op_addr;
  assign O_OP_DATA = s.op_data;

  // Checks on the driven behaviour
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RST);

  property p_fail_low;
    s.fail && s.cfg_mode && !s.od_mode |=> !O_PROG_FAIL_N_OUT && O_PROG_FAIL_N_OE;
  endproperty
  a_fail_low: assert property (p_fail_low) else $error("error pin not low");

  property p_fail_sticky;
    s.fail && !clr_cmd && !rst_clear |=> s.fail;
  endproperty
  a_fail_sticky: assert property (p_fail_sticky) else $error("error flag dropped");

  property p_busy_high;
    s.cfg_mode && !s.od_mode && !I_FLASH_BUSY && !I_SEC_WRITING && !s.op_start
      |=> O_PROG_BUSY_N_OUT;
  endproperty
  a_busy_high: assert property (p_busy_high) else $error("status not high");

  property p_busy_low;
    s.cfg_mode && (I_FLASH_BUSY || I_SEC_WRITING) |=> !O_PROG_BUSY_N_OUT && O_PROG_BUSY_N_OE;
  endproperty
  a_busy_low: assert property (p_busy_low) else $error("status not low");

  property p_gpio_idle;
    !s.cfg_mode |=> !O_PROG_BUSY_N_OE && !O_PROG_FAIL_N_OE && !O_TDO_OE;
  endproperty
  a_gpio_idle: assert property (p_gpio_idle) else $error("pin driven outside mode");

  property p_od_no_high;
    O_PROG_BUSY_N_OE && s.od_mode && $past(s.od_mode) |-> !O_PROG_BUSY_N_OUT;
  endproperty
  a_od_no_high: assert property (p_od_no_high) else $error("open-drain drove high");

  property p_secure_only_chip;
    O_OP_START && $past(s.secure) |-> O_OP_KIND == OP_CHIP;
  endproperty
  a_secure_only_chip: assert property (p_secure_only_chip) else $error("op while secured");

  property p_read_block;
    s.secure |=> O_READ_BLOCK;
  endproperty
  a_read_block: assert property (p_read_block) else $error("read not blocked");

  property p_protect;
    O_OP_START && O_OP_KIND == OP_SECT |-> sect_ok(O_OP_SECTOR, $past(I_SECTOR_PROTECT));
  endproperty
  a_protect: assert property (p_protect) else $error("protected sector erased");

  sequence s_chip_done;
    s.erase_pend && I_OP_DONE && !I_OP_FAIL;
  endsequence
  property p_unsecure;
    s_chip_done |=> !s.secure ##1 !O_READ_BLOCK;
  endproperty
  a_unsecure: assert property (p_unsecure) else $error("security not cleared");

  sequence s_en_write;
    I_REG_WR && I_REG_ADDR == PORT_EN_OFFSET && I_REG_WDATA[PORT_EN_BIT] && !dev_rst;
  endsequence
  property p_port_en;
    s_en_write |=> s.port_en ##1 O_TEST_PINS_ON;
  endproperty
  a_port_en: assert property (p_port_en) else $error("port enable ignored");

  property p_rst_clears;
    dev_rst |=> !s.port_en;
  endproperty
  a_rst_clears: assert property (p_rst_clears) else $error("enable survived reset");

  property p_rst_blocks;
    dev_rst && !I_NVM_DEDICATED |=> s.tap == TAP_TLR;
  endproperty
  a_rst_blocks: assert property (p_rst_blocks) else $error("port ran in reset");

endmodule : jtag_isp_status

/* File: test/jtag_isp_status_and_security_bench.sv */
// Self-checking bench for the test-port status, error, enable and security block.
// Assumes the host driver model on the test pins; the flash engine is modelled here.
`timescale 1ns/1ps
module jtag_isp_status_and_security_bench;
  import jtag_isp_pkg::*;
  logic I_CLK, I_RST, I_TCK, I_TMS, I_TDI, I_DEV_RESET_N, O_TDO, O_TDO_OE;
  logic O_PROG_BUSY_N_OUT, O_PROG_BUSY_N_OE, O_PROG_FAIL_N_OUT, O_PROG_FAIL_N_OE;
  logic I_NVM_DEDICATED, I_TEST_PINS_SELECT_TERM, O_TEST_PINS_ON, I_REG_WR;
  logic [7:0] I_REG_ADDR;
  logic [REG_W-1:0] I_REG_WDATA, O_REG_RDATA;
  logic I_SECURITY_BIT, O_READ_BLOCK, I_FLASH_BUSY, I_SEC_WRITING, I_OP_DONE, I_OP_FAIL;
  logic [SECT_N-1:0] I_SECTOR_PROTECT;
  logic [BYTE_W-1:0] I_READ_DATA, O_OP_ADDR, O_OP_DATA;
  logic O_OP_START, fail_next;
  logic [1:0] O_OP_KIND, got_kind;
  logic [SECT_W-1:0] O_OP_SECTOR, got_sect, s;
  logic [15:0] got_dr, v;
  int n_mismatch, checks_done, n_start, busy_left, seed, k;

  jtag_isp_status i_jtag_isp_status (
    .I_CLK(I_CLK), .I_RST(I_RST), .I_TCK(I_TCK), .I_TMS(I_TMS), .I_TDI(I_TDI),
    .I_DEV_RESET_N(I_DEV_RESET_N), .O_TDO(O_TDO), .O_TDO_OE(O_TDO_OE),
    .O_PROG_BUSY_N_OUT(O_PROG_BUSY_N_OUT), .O_PROG_BUSY_N_OE(O_PROG_BUSY_N_OE),
    .O_PROG_FAIL_N_OUT(O_PROG_FAIL_N_OUT), .O_PROG_FAIL_N_OE(O_PROG_FAIL_N_OE),
    .I_NVM_DEDICATED(I_NVM_DEDICATED), .I_TEST_PINS_SELECT_TERM(I_TEST_PINS_SELECT_TERM),
    .O_TEST_PINS_ON(O_TEST_PINS_ON), .I_REG_WR(I_REG_WR), .I_REG_ADDR(I_REG_ADDR),
    .I_REG_WDATA(I_REG_WDATA), .O_REG_RDATA(O_REG_RDATA), .I_SECURITY_BIT(I_SECURITY_BIT),
    .I_SECTOR_PROTECT(I_SECTOR_PROTECT), .O_READ_BLOCK(O_READ_BLOCK),
    .I_FLASH_BUSY(I_FLASH_BUSY), .I_SEC_WRITING(I_SEC_WRITING), .I_OP_DONE(I_OP_DONE),
    .I_OP_FAIL(I_OP_FAIL), .I_READ_DATA(I_READ_DATA), .O_OP_START(O_OP_START),
    .O_OP_KIND(O_OP_KIND), .O_OP_SECTOR(O_OP_SECTOR), .O_OP_ADDR(O_OP_ADDR),
    .O_OP_DATA(O_OP_DATA)
  );

  tap_host_model i_tap_host_model (
    .o_tck(I_TCK), .o_tms(I_TMS), .o_tdi(I_TDI), .i_tdo(O_TDO), .i_tdo_oe(O_TDO_OE)
  );

  // 50 MHz system clock
  initial begin
    I_CLK = 1'b0;
    forever #10 I_CLK = ~I_CLK;
  end

  // Flash engine: long random busy span per start so busy is seen after the update
  always @(negedge I_CLK) begin
    if (O_OP_START === 1'b1) begin
      n_start = n_start + 1;
      got_kind = O_OP_KIND;
      got_dr = {O_OP_DATA, O_OP_ADDR};
      got_sect = O_OP_SECTOR;
      busy_left = 20 + ($random(seed) & 15);
    end else if (busy_left > 0) begin
      busy_left = busy_left - 1;
    end
    I_FLASH_BUSY <= busy_left > 1;
    I_OP_DONE <= busy_left == 1;
    I_OP_FAIL <= busy_left == 1 && fail_next;
  end

  // Expected pin selection and sector-erase acceptance
  function automatic logic exp_pins(logic nvm, logic en, logic term);
    return nvm | en | term;
  endfunction : exp_pins

  function automatic logic exp_go(logic [SECT_W-1:0] sc, logic [SECT_N-1:0] p);
    return (sc < SECT_N) && !p[sc];
  endfunction : exp_go

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Register write; address returns to the enable register for read-back
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge I_CLK);
    I_REG_WR = 1'b1;
    I_REG_ADDR = a;
    I_REG_WDATA = d;
    @(negedge I_CLK);
    I_REG_WR = 1'b0;
    I_REG_ADDR = PORT_EN_OFFSET;
    repeat (3) @(negedge I_CLK);
  endtask : reg_wr

  task automatic cmd(input logic [IR_W-1:0] c);
    i_tap_host_model.shift_reg(1'b1, {8'h00, c}, IR_W);
    repeat (3) @(negedge I_CLK);
  endtask : cmd

  task automatic dr(input logic [15:0] d);
    i_tap_host_model.shift_reg(1'b0, d, DR_W);
    repeat (3) @(negedge I_CLK);
  endtask : dr

  // Security is sampled on the first edge after release
  task automatic do_reset(input logic sec);
    @(negedge I_CLK);
    I_RST = 1'b1;
    I_SECURITY_BIT = sec;
    repeat (3) @(negedge I_CLK);
    I_RST = 1'b0;
    repeat (8) @(negedge I_CLK);
    i_tap_host_model.reset_tap();
  endtask : do_reset

  task automatic pulse_dev();
    I_DEV_RESET_N = 1'b0;
    repeat (8) @(negedge I_CLK);
    I_DEV_RESET_N = 1'b1;
    repeat (8) @(negedge I_CLK);
  endtask : pulse_dev

  task automatic endt(input string n);
    $display("test %s finished", n);
  endtask : endt

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : wrap_up

  // Hang guard, well beyond the expected run of about 140 microseconds
  initial begin
    #1000000;
    n_mismatch++;
    $display("watchdog expired");
    wrap_up();
  end

  // Main sequence
  initial begin
    seed = 58905;
    {I_RST, I_DEV_RESET_N, I_NVM_DEDICATED, I_TEST_PINS_SELECT_TERM} = 4'h4;
    {I_REG_WR, I_SECURITY_BIT, I_SEC_WRITING, fail_next} = 4'h0;
    I_REG_ADDR = PORT_EN_OFFSET;
    I_REG_WDATA = 8'h00;
    I_SECTOR_PROTECT = 12'h000;
    I_READ_DATA = 8'h5A;
    do_reset(1'b0);
    chk(O_TDO_OE, 1'b0);
    chk({O_PROG_BUSY_N_OE, O_PROG_FAIL_N_OE}, 2'h0);
    chk(O_REG_RDATA, PORT_EN_RESET);
    chk({O_TEST_PINS_ON, O_READ_BLOCK}, 2'h0);
    endt("reset");
    // Every combination of the three selection sources, then a stray write
    for (int i = 0; i < 8; i++) begin
      {I_NVM_DEDICATED, I_TEST_PINS_SELECT_TERM} = i[2:1];
      reg_wr(PORT_EN_OFFSET, {7'h00, i[0]});
      chk(O_TEST_PINS_ON, exp_pins(i[2], i[0], i[1]));
      chk(O_REG_RDATA, {7'h00, i[0]});
    end
    {I_NVM_DEDICATED, I_TEST_PINS_SELECT_TERM} = 2'h0;
    reg_wr(PORT_EN_OFFSET, 8'h00);
    v = 16'($random(seed));
    reg_wr((v[7:0] == PORT_EN_OFFSET) ? 8'hC6 : v[7:0], 8'h01);
    chk({O_TEST_PINS_ON, O_REG_RDATA}, 9'h000);
    endt("enable");
    // Register-enabled pins give way to device reset; dedicated pins do not
    reg_wr(PORT_EN_OFFSET, 8'h01);
    I_DEV_RESET_N = 1'b0;
    repeat (8) @(negedge I_CLK);
    chk({O_TEST_PINS_ON, O_REG_RDATA}, 9'h000);
    // Pins switched on by another source still stay blocked in reset
    I_TEST_PINS_SELECT_TERM = 1'b1;
    cmd(CMD_ENTRY_PP);
    chk(O_TDO_OE, 1'b0);
    I_TEST_PINS_SELECT_TERM = 1'b0;
    I_DEV_RESET_N = 1'b1;
    repeat (8) @(negedge I_CLK);
    reg_wr(PORT_EN_OFFSET, 8'h01);
    i_tap_host_model.reset_tap();
    cmd(CMD_ENTRY_PP);
    chk(O_TDO_OE, 1'b1);
    I_NVM_DEDICATED = 1'b1;
    repeat (2) @(negedge I_CLK);
    I_DEV_RESET_N = 1'b0;
    repeat (8) @(negedge I_CLK);
    cmd(CMD_EXIT);
    chk(O_TDO_OE, 1'b0);
    cmd(CMD_ENTRY_PP);
    chk(O_TDO_OE, 1'b1);
    I_DEV_RESET_N = 1'b1;
    repeat (8) @(negedge I_CLK);
    endt("device_reset");
    chk({O_PROG_BUSY_N_OE, O_PROG_FAIL_N_OE}, 2'h3);
    chk({O_PROG_BUSY_N_OUT, O_PROG_FAIL_N_OUT}, 2'h3);
    I_SEC_WRITING = 1'b1;
    repeat (3) @(negedge I_CLK);
    chk(O_PROG_BUSY_N_OUT, 1'b0);
    I_SEC_WRITING = 1'b0;
    repeat (3) @(negedge I_CLK);
    chk(O_PROG_BUSY_N_OUT, 1'b1);
    // Random byte programs; the third fails and the flag must stick
    for (int i = 0; i < 4; i++) begin
      v = 16'($random(seed));
      fail_next = (i == 2);
      k = n_start;
      cmd(CMD_PROG);
      dr(v);
      chk(16'(n_start - k), 1);
      chk(got_kind, OP_PROG);
      chk(got_dr, v);
      chk(O_PROG_BUSY_N_OUT, 1'b0);
      repeat (40) @(negedge I_CLK);
      chk(O_PROG_BUSY_N_OUT, 1'b1);
      chk(O_PROG_FAIL_N_OUT, i < 2);
    end
    fail_next = 1'b0;
    pulse_dev();
    chk(O_PROG_FAIL_N_OUT, 1'b0);
    cmd(CMD_CLEAR);
    chk(O_PROG_FAIL_N_OUT, 1'b1);
    endt("program");
    // Sector erase over random protection, including sector 0 protected
    I_SECTOR_PROTECT = 12'($random(seed)) | 12'h001;
    for (int i = 0; i < 6; i++) begin
      v = 16'($random(seed));
      s = (i == 0) ? 4'h0 : v[3:0];
      k = n_start;
      cmd(CMD_SECT_ERASE);
      dr({12'h000, s});
      chk(16'(n_start - k), exp_go(s, I_SECTOR_PROTECT));
      if (exp_go(s, I_SECTOR_PROTECT)) begin
        chk({got_kind, got_sect}, {OP_SECT, s});
      end else begin
        chk(O_PROG_FAIL_N_OUT, 1'b0);
      end
      repeat (40) @(negedge I_CLK);
      cmd(CMD_CLEAR);
    end
    endt("sector");
    // Open-drain: enables only while pulling low
    cmd(CMD_EXIT);
    cmd(CMD_ENTRY_OD);
    chk({O_PROG_BUSY_N_OE, O_PROG_FAIL_N_OE}, 2'h0);
    fail_next = 1'b1;
    cmd(CMD_PROG);
    dr(16'($random(seed)));
    chk({O_PROG_BUSY_N_OUT, O_PROG_BUSY_N_OE}, 2'h1);
    repeat (40) @(negedge I_CLK);
    chk({O_PROG_FAIL_N_OUT, O_PROG_FAIL_N_OE}, 2'h1);
    fail_next = 1'b0;
    cmd(CMD_EXIT);
    pulse_dev();
    cmd(CMD_ENTRY_PP);
    chk(O_PROG_FAIL_N_OUT, 1'b1);
    endt("open_drain");
    // Secured part: reads blank, only chip erase goes through
    I_SECTOR_PROTECT = 12'h000;
    do_reset(1'b1);
    chk(O_READ_BLOCK, 1'b1);
    cmd(CMD_ENTRY_PP);
    I_READ_DATA = 8'($random(seed));
    cmd(CMD_READ);
    dr(16'h0000);
    chk(i_tap_host_model.last_out, 16'h0000);
    k = n_start;
    cmd(CMD_PROG);
    dr(16'($random(seed)));
    cmd(CMD_SECT_ERASE);
    dr(16'h0001);
    chk(16'(n_start - k), 0);
    cmd(CMD_CHIP_ERASE);
    chk({8'(n_start - k), 6'h00, got_kind}, {8'h01, 6'h00, OP_CHIP});
    repeat (40) @(negedge I_CLK);
    chk(O_READ_BLOCK, 1'b0);
    // Once unsecured, the array content comes out again
    cmd(CMD_READ);
    dr(16'h0000);
    chk(i_tap_host_model.last_out, {8'h00, I_READ_DATA});
    endt("security");
    wrap_up();
  end
endmodule : jtag_isp_status_and_security_bench

/* File: test/tap_host_model.sv */
// Host-side driver of the test pins: clocks instructions and data in.
// Assumes the device answers on TDO while driving it; TCK idles low between frames.
`timescale 1ns/1ps
module tap_host_model (
  // Test pins toward the device
  output logic o_tck,
  output logic o_tms,
  output logic o_tdi,
  // Test data return
  input wire logic i_tdo,
  input wire logic i_tdo_oe
);
  logic [15:0] last_out;

  // Idle levels; TCK stands still outside frames
  initial begin
    o_tck = 1'b0;
    o_tms = 1'b1;
    o_tdi = 1'b0;
    last_out = 16'h0000;
  end

  // One TCK period; TDO taken just before the fall, where it has settled
  // Only shift steps are kept, so last_out holds exactly the captured word
  task automatic step(input logic tms, input logic tdi, input logic cap = 1'b0);
    o_tms = tms;
    o_tdi = tdi;
    #80;
    o_tck = 1'b1;
    #80;
    if (cap) begin
      last_out = {(i_tdo_oe ? i_tdo : 1'b1), last_out[15:1]}; // Undriven reads as ones
    end
    o_tck = 1'b0;
  endtask : step

  // Five ones reach reset from any state, then park in idle
  task automatic reset_tap();
    repeat (5) step(1'b1, ~o_tdi);
    step(1'b0, ~o_tdi);
  endtask : reset_tap

  // Idle to shift, n bits LSB first, update, back to idle; TDI toggles when unused
  task automatic shift_reg(input logic ir, input logic [15:0] val, input int n);
    step(1'b1, ~o_tdi);
    if (ir) begin
      step(1'b1, ~o_tdi);
    end
    step(1'b0, ~o_tdi);
    step(1'b0, ~o_tdi);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, val[i], 1'b1);
    end
    step(1'b1, ~o_tdi);
    step(1'b0, ~o_tdi);
  endtask : shift_reg
endmodule : tap_host_model
